// File: hw/gpz_top.sv
// Port zero and port one register file and pin control
`timescale 1ns/1ps
module gpz_top (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  input  wire logic       rd_rmw,
  output logic      [7:0] rdata,
  // Standby state from the clock controller
  input  wire logic       stop_or_watch,
  // Port zero pins
  input  wire logic [7:0] p0_in,
  output logic      [7:0] p0_out,
  output logic      [7:0] p0_oe,
  output logic      [7:0] p0_pu,
  output logic      [7:0] p0_cmos_sel,
  // Port zero peripheral and interrupt side
  input  wire logic [7:0] p0_per_oe,
  input  wire logic [7:0] p0_per_out,
  input  wire logic [7:0] p0_irq_en,
  output logic      [7:0] p0_level,
  // Port one pin two
  input  wire logic       p1_in,
  output logic            p1_out,
  output logic            p1_oe,
  input  wire logic       p1_per_oe,
  input  wire logic       p1_per_out,
  output logic            p1_level
);
  typedef struct packed {
    logic [7:0] p0_latch;
    logic [7:0] p0_dir;
    logic [7:0] p0_pull;
    logic [7:0] analog_dis;
    logic [7:0] thresh;
    logic [7:0] p1_latch;
    logic [7:0] p1_dir;
    logic [7:0] standby;
    logic [7:0] rdata;
    logic [7:0] p0_out;
    logic [7:0] p0_oe;
    logic [7:0] p0_pu;
    logic [7:0] p0_cmos;
    logic [7:0] p0_level;
    logic       p1_out;
    logic       p1_oe;
    logic       p1_level;
    logic       in_reset;
  } gpz_top_s;

  gpz_top_s   st;
  gpz_top_s   next_st;
  logic [7:0] p0_sync;
  logic [0:0] p1_sync;
  logic       float_act;
  logic [7:0] dig_en;
  logic [7:0] po_out;
  logic [7:0] po_oe;
  logic [7:0] po_pu;
  logic [7:0] po_gate;
  logic       q_out;
  logic       q_oe;
  logic       q_gate;
  logic [7:0] p0_read;
  logic [7:0] p1_read;

  // Synchronise pin levels before any logic reads them
  gpz_sync #(.W(8)) u_sync0 (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (p0_in),
    .q     (p0_sync)
  );
  gpz_sync #(.W(1)) u_sync1 (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (p1_in),
    .q     (p1_sync)
  );

  // Standby float and digital input enables
  assign float_act = stop_or_watch & st.standby[gpz_pkg::FLOAT_BIT];
  assign dig_en    = st.analog_dis | ~gpz_pkg::ANALOG_MASK;

  // Per-pin decisions for port zero
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      gpz_pin u_pin (
        .latch      (st.p0_latch[i]),
        .dir        (st.p0_dir[i]),
        .pull_en    (st.p0_pull[i]),
        .dig_en     (dig_en[i]),
        .open_drain (1'b0),
        .per_oe     (p0_per_oe[i]),
        .per_out    (p0_per_out[i]),
        .float_act  (float_act),
        .irq_en     (p0_irq_en[i]),
        .pad_out    (po_out[i]),
        .pad_oe     (po_oe[i]),
        .pad_pu     (po_pu[i]),
        .gate_en    (po_gate[i])
      );
    end
  endgenerate

  // Port one pin two decision
  gpz_pin u_pin1 (
    .latch      (st.p1_latch[gpz_pkg::P1_PIN]),
    .dir        (st.p1_dir[gpz_pkg::P1_PIN]),
    .pull_en    (1'b0),
    .dig_en     (1'b1),
    .open_drain (gpz_pkg::P1_OPEN_DRAIN),
    .per_oe     (p1_per_oe),
    .per_out    (p1_per_out),
    .float_act  (float_act),
    .irq_en     (1'b0),
    .pad_out    (q_out),
    .pad_oe     (q_oe),
    .pad_pu     (),
    .gate_en    (q_gate)
  );

  // Read values: latch for output pins or read-modify-write, else gated pin level
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (rd_rmw || (st.p0_dir[b] && !p0_per_oe[b])) begin
        p0_read[b] = st.p0_latch[b];
      end else begin
        p0_read[b] = p0_sync[b] & po_gate[b];
      end
    end
    p1_read = 8'h00;
    if (rd_rmw || (st.p1_dir[gpz_pkg::P1_PIN] && !p1_per_oe)) begin
      p1_read[gpz_pkg::P1_PIN] = st.p1_latch[gpz_pkg::P1_PIN];
    end else begin
      p1_read[gpz_pkg::P1_PIN] = p1_sync[0] & q_gate;
    end
  end

  // Register writes, read mux and registered pin outputs
  always_comb begin
    next_st = st;
    next_st.in_reset = 1'b0;
    if (wr) begin
      case (addr)
        gpz_pkg::ADDR_P0_LATCH:   next_st.p0_latch   = wdata;
        gpz_pkg::ADDR_P0_DIR:     next_st.p0_dir     = wdata;
        gpz_pkg::ADDR_P0_PULLUP:  next_st.p0_pull    = wdata;
        gpz_pkg::ADDR_ANALOG_DIS: next_st.analog_dis = wdata & gpz_pkg::ANALOG_MASK;
        gpz_pkg::ADDR_THRESHOLD:  next_st.thresh     = wdata;
        gpz_pkg::ADDR_P1_LATCH:   next_st.p1_latch   = wdata;
        gpz_pkg::ADDR_P1_DIR:     next_st.p1_dir     = wdata;
        gpz_pkg::ADDR_STANDBY:    next_st.standby    = wdata;
        default:                  next_st.standby    = st.standby;
      endcase
    end
    next_st.rdata = 8'h00;
    if (rd) begin
      case (addr)
        gpz_pkg::ADDR_P0_LATCH:   next_st.rdata = p0_read;
        gpz_pkg::ADDR_P0_DIR:     next_st.rdata = st.p0_dir;
        gpz_pkg::ADDR_P0_PULLUP:  next_st.rdata = st.p0_pull;
        gpz_pkg::ADDR_ANALOG_DIS: next_st.rdata = st.analog_dis;
        gpz_pkg::ADDR_THRESHOLD:  next_st.rdata = st.thresh;
        gpz_pkg::ADDR_P1_LATCH:   next_st.rdata = p1_read;
        gpz_pkg::ADDR_P1_DIR:     next_st.rdata = st.p1_dir;
        gpz_pkg::ADDR_STANDBY:    next_st.rdata = st.standby;
        default:                  next_st.rdata = 8'h00;
      endcase
    end
    next_st.p0_out   = po_out;
    next_st.p0_oe    = po_oe;
    next_st.p0_pu    = po_pu;
    next_st.p0_level = p0_sync & po_gate;
    next_st.p0_cmos  = 8'h00;
    next_st.p0_cmos[gpz_pkg::CMOS_PIN] = st.thresh[gpz_pkg::THRESH_BIT];
    next_st.p1_out   = q_out;
    next_st.p1_oe    = q_oe;
    next_st.p1_level = p1_sync[0] & q_gate;
    if (!rst_n) begin
      next_st            = '0;
      next_st.p0_latch   = gpz_pkg::RESET_BYTE;
      next_st.p0_dir     = gpz_pkg::RESET_BYTE;
      next_st.p0_pull    = gpz_pkg::RESET_BYTE;
      next_st.analog_dis = gpz_pkg::RESET_BYTE;
      next_st.thresh     = gpz_pkg::RESET_BYTE;
      next_st.p1_latch   = gpz_pkg::RESET_BYTE;
      next_st.p1_dir     = gpz_pkg::RESET_BYTE;
      next_st.standby    = gpz_pkg::RESET_BYTE;
      next_st.in_reset   = 1'b1;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  assign rdata       = st.rdata;
  assign p0_out      = st.p0_out;
  assign p0_oe       = st.p0_oe;
  assign p0_pu       = st.p0_pu;
  assign p0_cmos_sel = st.p0_cmos;
  assign p0_level    = st.p0_level;
  assign p1_out      = st.p1_out;
  assign p1_oe       = st.p1_oe;
  assign p1_level    = st.p1_level;

  // Checks on register and pin behaviour
  // Reset clears direction and analog-disable bits
  a_reset_clears_dir: assert property (@(posedge mclk)
    !rst_n |=> st.p0_dir == 8'h00 && st.analog_dis == 8'h00)
    else $error("direction or analog bits not cleared by reset");
  // Pins float and input gates stay shut while the reset state is held
  a_reset_pins_float: assert property (@(posedge mclk)
    st.in_reset |-> p0_oe == 8'h00 && p0_level == 8'h00 && !p1_oe && !p1_level)
    else $error("pins driven after reset");
  // Forced float releases every pad
  a_float_no_drive: assert property (@(posedge mclk) disable iff (!rst_n)
    float_act |=> p0_oe == 8'h00 && !p1_oe)
    else $error("pin driven in forced float");
  // Without peripherals the enables follow the direction bits
  a_out_follows_dir: assert property (@(posedge mclk) disable iff (!rst_n)
    (!float_act && p0_per_oe == 8'h00) |=> p0_oe == $past(st.p0_dir))
    else $error("output enable does not follow direction");
  // Without peripherals the pad value is the latch
  a_out_latch_value: assert property (@(posedge mclk) disable iff (!rst_n)
    (p0_per_oe == 8'h00) |=> p0_out == $past(st.p0_latch))
    else $error("pin value differs from latch");
  // Read-modify-write read returns the latch
  a_rmw_reads_latch: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd && rd_rmw && addr == gpz_pkg::ADDR_P0_LATCH) |=> rdata == $past(st.p0_latch))
    else $error("read-modify-write read not latch");
  // No pull-up on any pad that drives low
  a_pullup_low_off: assert property (@(posedge mclk) disable iff (!rst_n)
    (p0_pu & p0_oe & ~p0_out) == 8'h00)
    else $error("pull-up on while driving low");
  // Only pin four can select the CMOS threshold
  a_cmos_only_four: assert property (@(posedge mclk) disable iff (!rst_n)
    (p0_cmos_sel & 8'hef) == 8'h00)
    else $error("CMOS select outside pin four");
  // An enabled interrupt input on a digital pin still passes in forced float
  a_irq_path_open: assert property (@(posedge mclk) disable iff (!rst_n)
    (float_act && p0_irq_en[7] && p0_sync[7]) |=> p0_level[7])
    else $error("interrupt input blocked in float");
  // Port one reads only bit two
  a_p1_unused_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    rd && addr == gpz_pkg::ADDR_P1_LATCH |=> (rdata & 8'hfb) == 8'h00)
    else $error("port one unused bits read nonzero");
  // Direction write lands in one cycle
  a_dir_write_lands: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr && addr == gpz_pkg::ADDR_P0_DIR) |=> st.p0_dir == $past(wdata))
    else $error("direction write lost");
  // Latch write is stored whatever the direction
  a_latch_write_lands: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr && addr == gpz_pkg::ADDR_P0_LATCH) |=> st.p0_latch == $past(wdata))
    else $error("latch write lost");
  // Pull-up write lands in one cycle
  a_pull_write_lands: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr && addr == gpz_pkg::ADDR_P0_PULLUP) |=> st.p0_pull == $past(wdata))
    else $error("pull-up write lost");
  // Analog-disable write keeps only the analog-capable bits
  a_analog_write_lands: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr && addr == gpz_pkg::ADDR_ANALOG_DIS) |=> st.analog_dis == ($past(wdata) & gpz_pkg::ANALOG_MASK))
    else $error("analog-disable write wrong");
  // Threshold write lands in one cycle
  a_thresh_write_lands: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr && addr == gpz_pkg::ADDR_THRESHOLD) |=> st.thresh == $past(wdata))
    else $error("threshold write lost");
  // Standby float write lands in one cycle
  a_standby_write_lands: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr && addr == gpz_pkg::ADDR_STANDBY) |=> st.standby == $past(wdata))
    else $error("standby write lost");
  // A pin with neither direction nor peripheral enable is never driven
  a_input_no_drive: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> (p0_oe & ~$past(st.p0_dir | p0_per_oe)) == 8'h00)
    else $error("input pin driven");
  // Peripheral output enable drives the pad
  a_per_drives_pin: assert property (@(posedge mclk) disable iff (!rst_n)
    !float_act |=> (p0_oe & $past(p0_per_oe)) == $past(p0_per_oe))
    else $error("peripheral pin not driven");
  // Peripheral value reaches the pad
  a_per_value_out: assert property (@(posedge mclk) disable iff (!rst_n)
    (p0_per_oe != 8'h00) |=> (p0_out & $past(p0_per_oe)) == ($past(p0_per_out) & $past(p0_per_oe)))
    else $error("peripheral value not on pin");
  // Normal read of a port output returns the latch
  a_out_read_latch: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd && !rd_rmw && addr == gpz_pkg::ADDR_P0_LATCH) |=>
      ((rdata ^ $past(st.p0_latch)) & $past(st.p0_dir & ~p0_per_oe)) == 8'h00)
    else $error("output pin read not latch");
  // Normal read of other pins returns the gated pin level
  a_in_read_pin: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd && !rd_rmw && addr == gpz_pkg::ADDR_P0_LATCH) |=>
      ((rdata ^ $past(p0_sync & po_gate)) & ~$past(st.p0_dir & ~p0_per_oe)) == 8'h00)
    else $error("input pin read not pin level");
  // Analog-selected pins that are not port outputs read low
  a_analog_read_low: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd && !rd_rmw && addr == gpz_pkg::ADDR_P0_LATCH) |=>
      (rdata & ~$past(st.p0_dir & ~p0_per_oe) & ~$past(st.analog_dis) & gpz_pkg::ANALOG_MASK) == 8'h00)
    else $error("analog pin read not low");
  // Forced float holds blocked inputs low
  a_float_input_low: assert property (@(posedge mclk) disable iff (!rst_n)
    float_act |=> (p0_level & ~$past(p0_irq_en)) == 8'h00 && !p1_level)
    else $error("blocked input not low");
  // Standby without float keeps the pad enables
  a_keep_no_float: assert property (@(posedge mclk) disable iff (!rst_n)
    (stop_or_watch && !st.standby[gpz_pkg::FLOAT_BIT] && p0_per_oe == 8'h00) |=> p0_oe == $past(st.p0_dir))
    else $error("pins changed in standby without float");
  // Pull-up setting stays in effect in forced float
  a_float_pull_kept: assert property (@(posedge mclk) disable iff (!rst_n)
    float_act |=> p0_pu == $past(st.p0_pull))
    else $error("pull-up lost in forced float");
  // Pull-up never connects without its bit
  a_pullup_needs_bit: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> (p0_pu & ~$past(st.p0_pull)) == 8'h00)
    else $error("pull-up on without enable");
  // Digital pins feed their level to the interrupt side
  a_level_to_irq: assert property (@(posedge mclk) disable iff (!rst_n)
    !float_act |=> ((p0_level ^ $past(p0_sync)) & $past(st.analog_dis | ~gpz_pkg::ANALOG_MASK)) == 8'h00)
    else $error("pin level not passed to interrupt side");
  // Analog-disable bits exist only for pins zero to five
  a_analog_dis_mask: assert property (@(posedge mclk) disable iff (!rst_n)
    (st.analog_dis & ~gpz_pkg::ANALOG_MASK) == 8'h00)
    else $error("analog-disable bit above pin five");
  // Threshold bit reaches pin four select
  a_cmos_follows_sel: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> p0_cmos_sel[gpz_pkg::CMOS_PIN] == $past(st.thresh[gpz_pkg::THRESH_BIT]))
    else $error("pin four threshold select wrong");
  // Port one enable follows its direction bit
  a_p1_dir_drives: assert property (@(posedge mclk) disable iff (!rst_n)
    (!float_act && !p1_per_oe) |=> p1_oe == $past(st.p1_dir[gpz_pkg::P1_PIN]))
    else $error("port one enable wrong");
  // Port one pad value is its latch bit
  a_p1_out_latch: assert property (@(posedge mclk) disable iff (!rst_n)
    !p1_per_oe |=> p1_out == $past(st.p1_latch[gpz_pkg::P1_PIN]))
    else $error("port one value differs from latch");
  // Port one read-modify-write read returns the latch bit
  a_p1_rmw_latch: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd && rd_rmw && addr == gpz_pkg::ADDR_P1_LATCH) |=> rdata[gpz_pkg::P1_PIN] == $past(st.p1_latch[gpz_pkg::P1_PIN]))
    else $error("port one read-modify-write read not latch");
endmodule

// File: hw/gpz_pkg.sv
// Constants and register map of the port zero and one block
package gpz_pkg;
  localparam logic [2:0] ADDR_P0_LATCH   = 3'h0;
  localparam logic [2:0] ADDR_P0_DIR     = 3'h1;
  localparam logic [2:0] ADDR_P0_PULLUP  = 3'h2;
  localparam logic [2:0] ADDR_ANALOG_DIS = 3'h3;
  localparam logic [2:0] ADDR_THRESHOLD  = 3'h4;
  localparam logic [2:0] ADDR_P1_LATCH   = 3'h5;
  localparam logic [2:0] ADDR_P1_DIR     = 3'h6;
  localparam logic [2:0] ADDR_STANDBY    = 3'h7;
  localparam logic [7:0] RESET_BYTE      = 8'h00;
  localparam logic [7:0] ANALOG_MASK     = 8'h3f;
  localparam int         THRESH_BIT      = 2;
  localparam int         CMOS_PIN        = 4;
  localparam int         P1_PIN          = 2;
  localparam int         FLOAT_BIT       = 0;
  localparam logic       P1_OPEN_DRAIN   = 1'b0;
endpackage

// File: hw/gpz_sync.sv
// Two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ps
module gpz_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } gpz_sync_s;
  gpz_sync_s st;
  gpz_sync_s next_st;

  // Shift the asynchronous level through two stages
  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
    if (!rst_n) begin
      next_st = '0;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  assign q = st.s2;
endmodule

// File: hw/gpz_pin.sv
// Per-pin output, pull-up and input-gate decision
`timescale 1ns/1ps
module gpz_pin (
  // Configuration
  input  wire logic latch,
  input  wire logic dir,
  input  wire logic pull_en,
  input  wire logic dig_en,
  input  wire logic open_drain,
  // Peripheral output
  input  wire logic per_oe,
  input  wire logic per_out,
  // Standby
  input  wire logic float_act,
  input  wire logic irq_en,
  // Pin decisions
  output logic      pad_out,
  output logic      pad_oe,
  output logic      pad_pu,
  output logic      gate_en
);
  logic drive;
  logic val;

  // Output selection: peripheral wins over port latch
  always_comb begin
    val = per_oe ? per_out : latch;
    drive = per_oe | dir;
    if (!per_oe && open_drain && latch) begin
      drive = 1'b0;
    end
    if (float_act) begin
      drive = 1'b0;
    end
    pad_out = val;
    pad_oe  = drive;
    pad_pu  = pull_en & ~(drive & ~val);
    gate_en = dig_en & (~float_act | irq_en);
  end
endmodule

// File: verif/gpz_board.sv
// Board model for the port pins
`timescale 1ns/1ps
module gpz_board (
  // Clock
  input  wire logic       mclk,
  // Port zero pads
  input  wire logic [7:0] p0_out,
  input  wire logic [7:0] p0_oe,
  input  wire logic [7:0] p0_pu,
  input  wire logic [7:0] ext0_oe,
  input  wire logic [7:0] ext0_val,
  output logic      [7:0] p0_in,
  // Port one pad
  input  wire logic       p1_out,
  input  wire logic       p1_oe,
  input  wire logic       ext1_oe,
  input  wire logic       ext1_val,
  output logic            p1_in
);
  logic [7:0] spin = 8'h00;
  // Undriven lines change every cycle
  always @(posedge mclk) spin <= ~spin;
  // Device driver first, then board driver, then pull-up on port zero only
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      p0_in[i] = p0_oe[i] ? p0_out[i] : ext0_oe[i] ? ext0_val[i] : p0_pu[i] ? 1'b1 : spin[i];
    end
    p1_in = p1_oe ? p1_out : ext1_oe ? ext1_val : spin[0];
  end
endmodule

// File: verif/gpz_top_tb.sv
// Self-checking bench for the port zero and one block
`timescale 1ns/1ps
module gpz_top_tb;
  logic       mclk, rst_n, wr, rd, rd_rmw, stop_or_watch, p1_in, p1_out, p1_oe, p1_level, p1_per_oe;
  logic       p1_per_out, ext1_oe, ext1_val, fl, e1oe, e1out, pin1, m1, sel1, rd1;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, p0_in, p0_out, p0_oe, p0_pu, p0_cmos_sel, p0_level, p0_per_oe, p0_per_out;
  logic [7:0] p0_irq_en, ext0_oe, ext0_val, lat, dir, pul, aid, thr, l1, d1, sb, po, eoe, eout, epu, gate, pin, m, sel;
  logic [31:0] r;
  int         n_errors, n_checks, cyc;

  gpz_top i_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rd_rmw(rd_rmw),
    .rdata(rdata), .stop_or_watch(stop_or_watch), .p0_in(p0_in), .p0_out(p0_out), .p0_oe(p0_oe), .p0_pu(p0_pu),
    .p0_cmos_sel(p0_cmos_sel), .p0_per_oe(p0_per_oe), .p0_per_out(p0_per_out), .p0_irq_en(p0_irq_en),
    .p0_level(p0_level), .p1_in(p1_in), .p1_out(p1_out), .p1_oe(p1_oe), .p1_per_oe(p1_per_oe),
    .p1_per_out(p1_per_out), .p1_level(p1_level));
  gpz_board i_board (.mclk(mclk), .p0_out(p0_out), .p0_oe(p0_oe), .p0_pu(p0_pu), .ext0_oe(ext0_oe),
    .ext0_val(ext0_val), .p0_in(p0_in), .p1_out(p1_out), .p1_oe(p1_oe), .ext1_oe(ext1_oe),
    .ext1_val(ext1_val), .p1_in(p1_in));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 8000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
  endtask

  // Read, then look at the data in the following cycle only
  task automatic rreg(input logic [2:0] a, input logic q, input logic [7:0] e, input logic [7:0] mk);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    rd_rmw <= q;
    @(posedge mclk);
    rd <= 1'b0;
    rd_rmw <= 1'b0;
    @(negedge mclk);
    chk8("rdata", e & mk, rdata & mk);
    @(posedge mclk);
  endtask

  // Expected pad state from the configuration
  function automatic void predict();
    eoe = fl ? 8'h00 : (dir | p0_per_oe);
    eout = (p0_per_oe & p0_per_out) | (~p0_per_oe & lat);
    epu = pul & ~(eoe & ~eout);
    gate = ((aid & gpz_pkg::ANALOG_MASK) | ~gpz_pkg::ANALOG_MASK) & (fl ? p0_irq_en : 8'hff);
    pin = (eoe & eout) | (~eoe & ext0_oe & ext0_val) | (~eoe & ~ext0_oe & epu);
    m = eoe | ext0_oe | epu;
    e1oe = ~fl & (d1[gpz_pkg::P1_PIN] | p1_per_oe);
    e1out = p1_per_oe ? p1_per_out : l1[gpz_pkg::P1_PIN];
    pin1 = e1oe ? e1out : ext1_oe & ext1_val;
    m1 = e1oe | ext1_oe;
  endfunction

  task automatic chk_pins();
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    fl = stop_or_watch & sb[gpz_pkg::FLOAT_BIT];
    predict();
    chk8("p0_oe", eoe, p0_oe);
    chk8("p0_out", eout & eoe, p0_out & eoe);
    chk8("p0_pu", epu, p0_pu);
    chk8("p0_level", pin & gate & m, p0_level & m);
    chk8("p0_cmos_sel", {3'h0, thr[gpz_pkg::THRESH_BIT], 4'h0}, p0_cmos_sel);
    chk8("p1_pad", {6'h0, e1oe, e1out & e1oe}, {6'h0, p1_oe, p1_out & e1oe});
    chk8("p1_level", {7'h0, pin1 & ~fl & m1}, {7'h0, p1_level & m1});
    @(posedge mclk);
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    chk8("p0_oe", 8'h00, p0_oe);
    chk8("p0_level", 8'h00, p0_level);
    @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rreg(gpz_pkg::ADDR_P0_DIR, 1'b0, gpz_pkg::RESET_BYTE, 8'hff);
    rreg(gpz_pkg::ADDR_ANALOG_DIS, 1'b0, gpz_pkg::RESET_BYTE, 8'hff);
  endtask

  // Main sequence
  initial begin
    {rst_n, wr, rd, rd_rmw, stop_or_watch, p1_per_oe, p1_per_out, ext1_oe, ext1_val} = 9'h0;
    {addr, wdata, p0_per_oe, p0_per_out, p0_irq_en, ext0_oe, ext0_val} = 43'h0;
    n_errors = 0;
    n_checks = 0;
    cyc = 0;
    void'($urandom(64));
    do_reset();
    for (int k = 0; k < 40; k++) begin
      r = $urandom;
      {lat, dir, pul, aid} = $urandom;
      {thr, l1, d1, sb} = $urandom;
      po = r[7:0];
      if (k == 0) {lat, dir, pul, po} = 32'h00ffff00;
      if (k == 1) {dir, aid, pul, po} = 32'h0;
      aid = aid | po;
      wreg(gpz_pkg::ADDR_P0_LATCH, lat);
      wreg(gpz_pkg::ADDR_P0_DIR, dir);
      wreg(gpz_pkg::ADDR_P0_PULLUP, pul);
      wreg(gpz_pkg::ADDR_ANALOG_DIS, aid);
      wreg(gpz_pkg::ADDR_THRESHOLD, thr);
      wreg(gpz_pkg::ADDR_P1_LATCH, l1);
      wreg(gpz_pkg::ADDR_P1_DIR, d1);
      wreg(gpz_pkg::ADDR_STANDBY, sb);
      wr <= 1'b0;
      p0_per_oe <= po;
      p0_per_out <= r[15:8];
      p0_irq_en <= r[23:16];
      ext0_val <= r[31:24];
      r = $urandom;
      ext0_oe <= r[15:8] & ~(dir | po);
      {ext1_val, p1_per_out, p1_per_oe} <= r[2:0];
      ext1_oe <= r[3] & ~(d1[gpz_pkg::P1_PIN] | r[0]);
      chk_pins();
      sel = dir & ~p0_per_oe;
      rreg(gpz_pkg::ADDR_P0_LATCH, 1'b0, (sel & lat) | (~sel & pin & gate), sel | m);
      rreg(gpz_pkg::ADDR_P0_LATCH, 1'b1, lat, 8'hff);
      rreg(gpz_pkg::ADDR_P0_PULLUP, 1'b0, pul, 8'hff);
      rreg(gpz_pkg::ADDR_ANALOG_DIS, 1'b0, aid & gpz_pkg::ANALOG_MASK, 8'hff);
      rreg(gpz_pkg::ADDR_THRESHOLD, 1'b0, thr, 8'h04);
      rreg(gpz_pkg::ADDR_P1_LATCH, 1'b1, l1, 8'h04);
      rreg(gpz_pkg::ADDR_P1_DIR, 1'b0, d1, 8'h04);
      rreg(gpz_pkg::ADDR_P0_DIR, 1'b0, dir, 8'hff);
      rreg(gpz_pkg::ADDR_STANDBY, 1'b0, sb, 8'hff);
      sel1 = d1[gpz_pkg::P1_PIN] & ~p1_per_oe;
      rd1 = sel1 ? l1[gpz_pkg::P1_PIN] : pin1;
      rreg(gpz_pkg::ADDR_P1_LATCH, 1'b0, {5'h0, rd1, 2'h0}, {5'h0, sel1 | m1, 2'h0});
      stop_or_watch <= 1'b1;
      chk_pins();
      stop_or_watch <= 1'b0;
      {p0_per_oe, p0_irq_en, p1_per_oe} <= 17'h0;
    end
    do_reset();
    summarize();
  end
endmodule
